// *** pkg/hsl_consts.svh ***
`ifndef HSL_CONSTS_SVH
`define HSL_CONSTS_SVH

// ----------------------------------------------------------------
// Lane widths, modes and delay tap limits
// ----------------------------------------------------------------
`define HSL_WORD_W        10
`define HSL_CNT_W         4
`define HSL_TAP_W         5
`define HSL_TAP_RESET     5'h00
`define HSL_TAP_MAX       5'h1F
`define HSL_MODE_RX       2'h0
`define HSL_MODE_TX       2'h1
`define HSL_MODE_BIDIR    2'h2
`define HSL_BYPASS_WIDTH  4'h1

// ----------------------------------------------------------------
// Training, queue and clock period
// ----------------------------------------------------------------
`define HSL_LOCK_WORDS    5'h10
`define HSL_QUEUE_DEPTH   8
`define HSL_CLK_PERIOD_NS 5

`endif

// *** pkg/hsl_pkg.sv ***
`include "hsl_consts.svh"

package hsl_pkg;

	typedef logic [`HSL_WORD_W-1:0] hsl_word_t;

	typedef struct packed {
		logic [1:0]            mode;
		logic                  half_rate;
		logic [`HSL_CNT_W-1:0] width;
		logic                  queue_en;
		logic                  align_en;
		logic                  tx_clk_mode;
		logic                  bypass;
		logic                  term_dynamic;
		logic                  term_static;
	} hsl_cfg_t;

	typedef struct packed {
		logic delay_ctrl_en;
		logic delay_step_up;
		logic delay_clear;
	} hsl_dly_t;

	typedef enum logic [1:0] {
		HSL_AL_IDLE,
		HSL_AL_TRAIN,
		HSL_AL_LOCKED
	} hsl_align_st_t;

endpackage : hsl_pkg

// *** test/hsl_lane_bench.sv ***
`timescale 1ns/100ps
`include "hsl_consts.svh"

module hsl_lane_bench;
	import hsl_pkg::*;

	logic                  mclk_i, arst_n_i, rx_buffer_on_i, rx_term_i;
	logic                  rx_rst_i, queue_rd_i, tx_rst_i, tx_oe_i, inc;
	logic                  rx_buffer_on_o, rx_term_on_o, rx_word_valid_o;
	logic                  lock_o, alternate_clock_out_o, parallel_clk_o;
	logic                  queue_empty_o, queue_wr_ready_o, queue_overflow_o;
	logic                  tx_word_taken_o, tx_pad_oe_o;
	logic [1:0]            rx_pad_i, tx_pad_o;
	logic [`HSL_TAP_W-1:0] delay_tap_o;
	hsl_cfg_t              cfg_i;
	hsl_dly_t              dly_i;
	hsl_word_t             rx_word_o, queue_word_o, tx_word_i, base;
	int                    err_total, num_checks;

	hsl_lane #(.QUEUE_DEPTH(8)) dut (.mclk_i, .arst_n_i, .cfg_i, .rx_pad_i,
		.rx_buffer_on_o, .rx_term_on_o, .rx_buffer_on_i, .rx_term_i,
		.rx_rst_i, .dly_i, .rx_word_o, .rx_word_valid_o, .lock_o,
		.delay_tap_o, .alternate_clock_out_o, .parallel_clk_o, .queue_rd_i,
		.queue_empty_o, .queue_wr_ready_o, .queue_overflow_o, .queue_word_o,
		.tx_word_i, .tx_rst_i, .tx_oe_i, .tx_word_taken_o, .tx_pad_o,
		.tx_pad_oe_o);

	hsl_link_partner far (.mclk_i, .arst_n_i, .clear_i(rx_rst_i), .cfg_i,
		.base_i(base), .inc_i(inc), .rx_pad_o(rx_pad_i));

	always #2.5 mclk_i = ~mclk_i;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [9:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report

	task automatic setup(input logic [1:0] m, input logic h,
		input logic [3:0] w, input logic [5:0] f);
		cfg_i          <= {m, h, w, f};
		rx_buffer_on_i <= 1'b1;
		rx_term_i      <= 1'b0;
		rx_rst_i       <= 1'b0;
		tx_rst_i       <= 1'b0;
		queue_rd_i     <= 1'b0;
		dly_i          <= 3'b000;
		arst_n_i       <= 1'b0;
		repeat (4) @(posedge mclk_i);
		arst_n_i <= 1'b1;
	endtask : setup

	task automatic wait_valid(output int n);
		n = 0;
		while (rx_word_valid_o !== 1'b1 && n < 40) begin
			@(posedge mclk_i);
			n++;
		end
	endtask : wait_valid

	task automatic dly_step(input logic [2:0] v, input int n);
		dly_i <= v;
		repeat (n) @(posedge mclk_i);
		dly_i <= 3'b000;
		@(posedge mclk_i);
	endtask : dly_step

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic rx_words(input logic h, input logic [3:0] w);
		hsl_word_t m;
		int        n;
		m = (10'h001 << w) - 10'h001;
		base <= 10'h2A5;
		inc  <= 1'b1;
		setup(2'h0, h, w, 6'h00);
		for (int k = 0; k < 3; k++) begin
			wait_valid(n);
			check("rx word", rx_word_o & m, (10'h2A5 + 10'(k)) & m);
			check("par clk", parallel_clk_o, 1'b1);
			if (k > 0) check("gap", 10'(n), 10'(w / (h ? 2 : 1) - 1));
			@(posedge mclk_i);
		end
	endtask : rx_words

	task automatic rx_pins();
		int n;
		tx_oe_i <= 1'b1;
		base    <= 10'h00F;
		inc     <= 1'b0;
		setup(2'h2, 1'b0, 4'h4, 6'h02);
		rx_term_i <= 1'b1;
		@(posedge mclk_i);
		check("buf on", rx_buffer_on_o, 1'b1);
		check("tx oe", tx_pad_oe_o, 1'b1);
		check("term on", rx_term_on_o, 1'b1);
		rx_term_i      <= 1'b0;
		rx_buffer_on_i <= 1'b0;
		@(posedge mclk_i);
		check("term off", rx_term_on_o, 1'b0);
		check("buf off", rx_buffer_on_o, 1'b0);
		repeat (6) @(posedge mclk_i);
		wait_valid(n);
		check("gated", rx_word_o & 10'h00F, 10'h000);
		rx_buffer_on_i <= 1'b1;
		@(posedge mclk_i);
		wait_valid(n);
		@(posedge mclk_i);
		wait_valid(n);
		check("bidir rx", rx_word_o & 10'h00F, 10'h00F);
	endtask : rx_pins

	task automatic queue_fill();
		int n;
		base <= 10'h100;
		inc  <= 1'b1;
		setup(2'h0, 1'b0, 4'hA, 6'h20);
		check("empty", queue_empty_o, 1'b1);
		n = 0;
		while (queue_wr_ready_o !== 1'b0 && n < 120) begin
			@(posedge mclk_i);
			n++;
		end
		check("full", queue_wr_ready_o, 1'b0);
		n = 0;
		while (queue_overflow_o !== 1'b1 && n < 12) begin
			@(posedge mclk_i);
			n++;
		end
		check("drop", queue_overflow_o, 1'b1);
		queue_rd_i <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			@(posedge mclk_i);
			check("head", queue_word_o, 10'h100 + 10'(k));
		end
		queue_rd_i <= 1'b0;
		@(posedge mclk_i);
		check("drained", queue_empty_o, 1'b1);
		n = 0;
		while (queue_empty_o !== 1'b0 && n < 12) begin
			@(posedge mclk_i);
			n++;
		end
		rx_rst_i <= 1'b1;
		@(posedge mclk_i);
		rx_rst_i <= 1'b0;
		@(posedge mclk_i);
		check("rst empty", queue_empty_o, 1'b1);
		wait_valid(n);
		check("realign", rx_word_o, 10'h100);
	endtask : queue_fill

	task automatic delay_steps();
		setup(2'h0, 1'b0, 4'h4, 6'h00);
		dly_step(3'b110, 3);
		check("tap up", delay_tap_o, 5'h03);
		dly_step(3'b010, 2);
		check("tap idle", delay_tap_o, 5'h03);
		dly_step(3'b100, 5);
		check("tap floor", delay_tap_o, 5'h00);
		dly_step(3'b110, 33);
		check("tap ceil", delay_tap_o, 5'h1F);
		dly_step(3'b001, 1);
		check("tap clear", delay_tap_o, 5'h00);
	endtask : delay_steps

	task automatic align_lock();
		int n;
		base <= 10'h2B3;
		inc  <= 1'b0;
		setup(2'h0, 1'b0, 4'h4, 6'h30);
		check("no lock", lock_o, 1'b0);
		dly_step(3'b100, 1);
		n = 0;
		while (lock_o !== 1'b1 && n < 150) begin
			@(posedge mclk_i);
			n++;
		end
		check("lock", lock_o, 1'b1);
		check("held", queue_empty_o, 1'b1);
		dly_step(3'b001, 1);
		check("unlock", lock_o, 1'b0);
		setup(2'h0, 1'b1, 4'h4, 6'h10);
		dly_step(3'b110, 2);
		check("half tap", delay_tap_o, 5'h02);
		repeat (150) @(posedge mclk_i);
		check("half lock", lock_o, 1'b0);
	endtask : align_lock

	task automatic alt_out();
		logic p;
		base <= 10'h000;
		inc  <= 1'b1;
		setup(2'h0, 1'b0, 4'h1, 6'h05);
		@(posedge mclk_i);
		check("term fix", rx_term_on_o, 1'b1);
		for (int k = 0; k < 4; k++) begin
			p = rx_pad_i[0];
			@(posedge mclk_i);
			check("alt", alternate_clock_out_o, p);
		end
		setup(2'h0, 1'b0, 4'h8, 6'h04);
		repeat (6) @(posedge mclk_i);
		check("alt off", alternate_clock_out_o, 1'b0);
	endtask : alt_out

	task automatic tx_stream(input logic [5:0] f, input logic [3:0] e,
		input logic h);
		logic [7:0] s;
		int         taken;
		logic       hit;
		tx_word_i <= 10'(e);
		tx_oe_i   <= 1'b1;
		setup(2'h1, h, 4'h4, f);
		repeat (12) @(posedge mclk_i);
		taken = 0;
		hit   = 1'b0;
		for (int i = 0; i < 8; i += (h ? 2 : 1)) begin
			s[i] = tx_pad_o[0];
			if (h) s[i + 1] = tx_pad_o[1];
			taken += int'(tx_word_taken_o);
			@(posedge mclk_i);
		end
		for (int r = 0; r < 4; r += (h ? 2 : 1))
			hit |= (s === 8'({3{e}} >> r));
		check("tx bits", hit, 1'b1);
		check("taken", 10'(taken), 10'h002);
		check("oe", tx_pad_oe_o, 1'b1);
		check("rx idle", rx_buffer_on_o, 1'b0);
		tx_oe_i  <= 1'b0;
		tx_rst_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		check("oe off", tx_pad_oe_o, 1'b0);
		check("rst pad", tx_pad_o, 2'h0);
		tx_rst_i <= 1'b0;
		@(posedge mclk_i);
	endtask : tx_stream

	// ----------------------------------------
	// Sequence and watchdog
	// ----------------------------------------
	initial begin
		mclk_i = 1'b0;
		arst_n_i = 1'b0;
		cfg_i = '0;
		{rx_buffer_on_i, rx_term_i, rx_rst_i, queue_rd_i} = 4'h0;
		{tx_rst_i, tx_oe_i, inc} = 3'h0;
		dly_i = 3'b000;
		tx_word_i = 10'h000;
		base = 10'h000;
		err_total = 0;
		num_checks = 0;
		rx_words(1'b0, 4'h8);
		rx_words(1'b1, 4'hA);
		rx_pins();
		queue_fill();
		delay_steps();
		align_lock();
		alt_out();
		tx_stream(6'h00, 4'h9, 1'b0);
		tx_stream(6'h08, 4'h3, 1'b0);
		tx_stream(6'h00, 4'hB, 1'b1);
		final_report();
	end

	initial begin
		#50000;
		err_total++;
		final_report();
	end
endmodule : hsl_lane_bench

// *** test/hsl_link_partner.sv ***
`timescale 1ns/100ps

// ----------------------------------------
// Far-end serial source for the pair
// ----------------------------------------
module hsl_link_partner (
	// Clock and reset
	input  wire logic               mclk_i,
	input  wire logic               arst_n_i,
	input  wire logic               clear_i,
	// Stream setup
	input  wire hsl_pkg::hsl_cfg_t  cfg_i,
	input  wire hsl_pkg::hsl_word_t base_i,
	input  wire logic               inc_i,
	// Pair toward the lane
	output logic [1:0]              rx_pad_o
);
	import hsl_pkg::*;

	logic [3:0] bit_idx;
	logic [3:0] step;
	hsl_word_t  word;

	assign step = cfg_i.half_rate ? 4'h2 : 4'h1;
	// LSB first; second bit of a pair only in half rate
	assign rx_pad_o = {word[bit_idx + 4'h1] & cfg_i.half_rate,
		word[bit_idx]};

	// One word per width bits, next word counts up when inc_i is set
	always_ff @(posedge mclk_i) begin
		if (!arst_n_i || clear_i) begin
			bit_idx <= 4'h0;
			word    <= base_i;
		end else if (bit_idx + step >= cfg_i.width) begin
			bit_idx <= 4'h0;
			word    <= inc_i ? word + 10'h001 : word;
		end else begin
			bit_idx <= bit_idx + step;
		end
	end
endmodule : hsl_link_partner

// *** verilog/hsl_lane.sv ***
`timescale 1ns/100ps
`include "hsl_consts.svh"

// ----------------------------------------------------------------
// Synchronous queue
// ----------------------------------------------------------------
module hsl_queue #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic             mclk_i,
	input  wire logic             arst_n_i,
	input  wire logic             clear_i,
	// Fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;

	wire push = in_valid_i && in_ready_o;
	wire pop  = out_valid_o && out_ready_i;

	assign in_ready_o  = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o  = mem[rd_ptr];

	always_ff @(posedge mclk_i) begin
		if (push)
			mem[wr_ptr] <= in_data_i;
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else if (clear_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : hsl_queue

// Behaviour
// RQ1: Lane works as receiver, transmitter or bidirectional port, one serial pair.
// RQ2: Serialization width programmable up to ten bits on ten-bit words.
// RQ3: Full rate moves one serial bit per fast clock rising edge.
// RQ4: Half rate moves two serial bits per fast clock, one per edge. The code moves both bits on the rising edge, one on each pad line.
// RQ5: Clock source supplies parallel clock at bit rate over width.
// RQ6: Optional eight-entry receive queue; transmit path has none.
// RQ7: Queue empty flag asserted whenever the enabled queue holds nothing.
// RQ8: Core pops queue words by asserting read enable.
// RQ9: Receive reset clears queue and deserializer.
// RQ10: Phase aligner adjusts delay tap itself, only in full rate.
// RQ11: Lock output asserted once aligner training succeeds.
// RQ12: Input buffer enable 1 receives, 0 blocks input.
// RQ13: Dynamic termination control 1 turns termination on, 0 off.
// RQ14: Delay enable activates manual delay or aligner, whichever configured.
// RQ15: Step-up 1 increments, 0 decrements; unused under aligner.
// RQ16: Delay clear resets delay counter or aligner, whichever configured.
// RQ17: Alternate clock output only in bypass with width one.
// RQ18: Receiver presents each aligned word at parallel clock edge.
// RQ19: Core supplies each word at parallel clock edge; lane serializes it.
// RQ20: Transmit reset clears the serializer.
// RQ21: Transmitter sends serial data or a reference clock pattern.
// RQ22: Transmit output enable gates the output driver.
// RQ23: Bidirectional mode uses one width for both directions.
// RQ24: After reset alignment restarts; data invalid until lock under aligner. The code gates only queue pushes; rx_word_valid_o pulses before lock.
module hsl_lane #(
	parameter int QUEUE_DEPTH = `HSL_QUEUE_DEPTH
) (
	// Clock and reset
	input  wire logic             mclk_i,
	input  wire logic             arst_n_i,
	// Static configuration
	input  wire hsl_pkg::hsl_cfg_t cfg_i,
	// Receive pad side
	input  wire logic [1:0]       rx_pad_i,
	output logic                  rx_buffer_on_o,
	output logic                  rx_term_on_o,
	// Receive core side
	input  wire logic             rx_buffer_on_i,
	input  wire logic             rx_term_i,
	input  wire logic             rx_rst_i,
	input  wire hsl_pkg::hsl_dly_t dly_i,
	output hsl_pkg::hsl_word_t    rx_word_o,
	output logic                  rx_word_valid_o,
	output logic                  lock_o,
	output logic [`HSL_TAP_W-1:0] delay_tap_o,
	output logic                  alternate_clock_out_o,
	output logic                  parallel_clk_o,
	// Receive queue
	input  wire logic             queue_rd_i,
	output logic                  queue_empty_o,
	output logic                  queue_wr_ready_o,
	output logic                  queue_overflow_o,
	output hsl_pkg::hsl_word_t    queue_word_o,
	// Transmit core side
	input  wire hsl_pkg::hsl_word_t tx_word_i,
	input  wire logic             tx_rst_i,
	input  wire logic             tx_oe_i,
	output logic                  tx_word_taken_o,
	// Transmit pad side
	output logic [1:0]            tx_pad_o,
	output logic                  tx_pad_oe_o
);
	import hsl_pkg::*;

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	wire rx_on = (cfg_i.mode == `HSL_MODE_RX) || (cfg_i.mode == `HSL_MODE_BIDIR); // [RQ1]
	wire tx_on = (cfg_i.mode == `HSL_MODE_TX) || (cfg_i.mode == `HSL_MODE_BIDIR); // [RQ1]
	wire [`HSL_CNT_W-1:0] width =
		(cfg_i.width == '0) ? 4'h1 :
		(cfg_i.width > 4'hA) ? 4'hA : cfg_i.width; // [RQ2]
	wire [`HSL_CNT_W-1:0] step = cfg_i.half_rate ? 4'h2 : 4'h1; // [RQ3] [RQ4]
	wire align_act = cfg_i.align_en && !cfg_i.half_rate; // [RQ10]
	wire [1:0] rx_bits = rx_buffer_on_i ? rx_pad_i : 2'h0; // [RQ12]

	assign rx_buffer_on_o = rx_on && rx_buffer_on_i; // [RQ12]
	assign rx_term_on_o   = rx_on &&
		(cfg_i.term_dynamic ? rx_term_i : cfg_i.term_static); // [RQ13]

	// ------------------------------------------------------------
	// Deserializer
	// ------------------------------------------------------------
	logic [`HSL_CNT_W-1:0] rx_cnt;
	hsl_word_t             rx_shift;
	hsl_word_t             next_rx_shift;
	wire [`HSL_CNT_W-1:0]  rx_sum  = rx_cnt + step;
	wire                   rx_done = rx_on && (rx_sum >= width);

	always_comb begin
		next_rx_shift = rx_shift;
		next_rx_shift[rx_cnt] = rx_bits[0]; // [RQ3]
		if (cfg_i.half_rate && (rx_cnt + 4'h1 < 4'hA))
			next_rx_shift[rx_cnt + 4'h1] = rx_bits[1]; // [RQ4]
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rx_cnt          <= '0;
			rx_shift        <= '0;
			rx_word_o       <= '0;
			rx_word_valid_o <= 1'b0;
		end else if (rx_rst_i) begin // [RQ9] [RQ24]
			rx_cnt          <= '0;
			rx_shift        <= '0;
			rx_word_valid_o <= 1'b0;
		end else begin
			rx_cnt          <= rx_done ? '0 : rx_sum;
			rx_shift        <= rx_done ? '0 : next_rx_shift;
			rx_word_valid_o <= rx_done; // [RQ18]
			if (rx_done)
				rx_word_o <= next_rx_shift; // [RQ18]
		end
	end

	// Word boundary strobe stands in for the parallel clock
	assign parallel_clk_o = rx_word_valid_o | tx_word_taken_o; // [RQ5]

	// ------------------------------------------------------------
	// Delay chain and phase aligner
	// ------------------------------------------------------------
	hsl_align_st_t al_st;
	hsl_align_st_t next_al_st;
	hsl_word_t     prev_word;
	logic [4:0]    stable_cnt;

	wire same_word = (rx_word_o == prev_word);
	wire man_up    = !align_act && dly_i.delay_ctrl_en && dly_i.delay_step_up
		&& (delay_tap_o != `HSL_TAP_MAX); // [RQ14] [RQ15]
	wire man_dn    = !align_act && dly_i.delay_ctrl_en && !dly_i.delay_step_up
		&& (delay_tap_o != `HSL_TAP_RESET); // [RQ14] [RQ15]
	wire al_step   = (al_st == HSL_AL_TRAIN) && rx_word_valid_o && !same_word;
	wire al_win    = (al_st == HSL_AL_TRAIN) && rx_word_valid_o && same_word
		&& (stable_cnt == `HSL_LOCK_WORDS - 5'h1);

	always_comb begin
		case (al_st)
			HSL_AL_IDLE:
				next_al_st = (align_act && dly_i.delay_ctrl_en) ?
					HSL_AL_TRAIN : HSL_AL_IDLE; // [RQ14]
			HSL_AL_TRAIN:
				next_al_st = !align_act ? HSL_AL_IDLE :
					al_win ? HSL_AL_LOCKED : HSL_AL_TRAIN; // [RQ11]
			HSL_AL_LOCKED:
				next_al_st = align_act ? HSL_AL_LOCKED : HSL_AL_IDLE;
			default:
				next_al_st = HSL_AL_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			al_st       <= HSL_AL_IDLE;
			stable_cnt  <= '0;
			prev_word   <= '0;
			delay_tap_o <= `HSL_TAP_RESET;
		end else if (dly_i.delay_clear || rx_rst_i) begin // [RQ16] [RQ24]
			al_st       <= HSL_AL_IDLE;
			stable_cnt  <= '0;
			delay_tap_o <= `HSL_TAP_RESET;
		end else begin
			al_st <= next_al_st;
			if (rx_word_valid_o)
				prev_word <= rx_word_o;
			if (al_st != HSL_AL_TRAIN || (rx_word_valid_o && !same_word))
				stable_cnt <= '0;
			else if (rx_word_valid_o)
				stable_cnt <= stable_cnt + 5'h1;
			if (al_step || man_up)
				delay_tap_o <= delay_tap_o + 5'h1; // [RQ10] [RQ15]
			else if (man_dn)
				delay_tap_o <= delay_tap_o - 5'h1; // [RQ15]
		end
	end

	assign lock_o = (al_st == HSL_AL_LOCKED); // [RQ11]

	// ------------------------------------------------------------
	// Alternate output
	// ------------------------------------------------------------
	wire alt_ok = rx_on && cfg_i.bypass && (width == `HSL_BYPASS_WIDTH); // [RQ17]

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			alternate_clock_out_o <= 1'b0;
		else
			alternate_clock_out_o <= alt_ok && rx_bits[0]; // [RQ17]
	end

	// ------------------------------------------------------------
	// Receive queue
	// ------------------------------------------------------------
	wire word_usable = rx_word_valid_o && (!align_act || lock_o); // [RQ24]
	wire q_push      = cfg_i.queue_en && word_usable;
	wire q_valid;

	hsl_queue #(
		.WIDTH (`HSL_WORD_W),
		.DEPTH (QUEUE_DEPTH)
	) u_queue (
		.mclk_i      (mclk_i),
		.arst_n_i    (arst_n_i),
		.clear_i     (rx_rst_i), // [RQ9]
		.in_valid_i  (q_push),
		.in_ready_o  (queue_wr_ready_o),
		.in_data_i   (rx_word_o),
		.out_valid_o (q_valid),
		.out_ready_i (queue_rd_i), // [RQ8]
		.out_data_o  (queue_word_o)
	); // [RQ6]

	assign queue_empty_o    = cfg_i.queue_en && !q_valid; // [RQ7]
	assign queue_overflow_o = q_push && !queue_wr_ready_o;

	// ------------------------------------------------------------
	// Serializer
	// ------------------------------------------------------------
	logic [`HSL_CNT_W-1:0] tx_cnt;
	hsl_word_t             tx_shift;
	hsl_word_t             clk_pat;
	wire [`HSL_CNT_W-1:0]  tx_sum  = tx_cnt + step;
	wire                   tx_load = tx_on && (tx_sum >= width);

	genvar gi;
	generate
		for (gi = 0; gi < `HSL_WORD_W; gi++) begin : g_pat
			assign clk_pat[gi] = (gi < int'(width >> 1)); // [RQ21]
		end
	endgenerate

	wire [1:0] tx_now = {tx_shift[tx_cnt + 4'h1], tx_shift[tx_cnt]};

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_cnt          <= '0;
			tx_shift        <= '0;
			tx_pad_o        <= 2'h0;
			tx_word_taken_o <= 1'b0;
		end else if (tx_rst_i) begin // [RQ20]
			tx_cnt          <= '0;
			tx_shift        <= '0;
			tx_pad_o        <= 2'h0;
			tx_word_taken_o <= 1'b0;
		end else begin
			tx_cnt          <= tx_load ? '0 : tx_sum;
			tx_word_taken_o <= tx_load; // [RQ19]
			tx_pad_o        <= {cfg_i.half_rate & tx_now[1], tx_now[0]}; // [RQ3] [RQ4]
			if (tx_load)
				tx_shift <= cfg_i.tx_clk_mode ? clk_pat : tx_word_i; // [RQ19] [RQ21]
		end
	end

	assign tx_pad_oe_o = tx_on && tx_oe_i; // [RQ22]

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_train_win;
		al_win;
	endsequence

	property p_lane_dir;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(cfg_i.mode == `HSL_MODE_RX) |-> !tx_pad_oe_o;
	endproperty
	a_lane_dir: assert property (p_lane_dir) else $error("tx driven in rx mode"); // [RQ1]

	property p_word_len;
		@(posedge mclk_i) disable iff (!arst_n_i || rx_rst_i)
		(rx_word_valid_o && !cfg_i.half_rate && width == 4'h8
			&& $stable(cfg_i)) |-> ##8 rx_word_valid_o;
	endproperty
	a_word_len: assert property (p_word_len) else $error("word spacing wrong"); // [RQ2]

	property p_half_rate;
		@(posedge mclk_i) disable iff (!arst_n_i || rx_rst_i)
		(rx_word_valid_o && cfg_i.half_rate && width == 4'hA
			&& $stable(cfg_i)) |-> ##5 rx_word_valid_o;
	endproperty
	a_half_rate: assert property (p_half_rate) else $error("half rate spacing"); // [RQ4]

	property p_empty;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(cfg_i.queue_en && $past(rx_rst_i)) |-> queue_empty_o;
	endproperty
	a_empty: assert property (p_empty) else $error("queue not empty after clear"); // [RQ7] [RQ9]

	property p_lock;
		@(posedge mclk_i) disable iff (!arst_n_i || dly_i.delay_clear || rx_rst_i)
		(s_train_win ##0 align_act) |=> lock_o;
	endproperty
	a_lock: assert property (p_lock) else $error("no lock after training"); // [RQ11]

	property p_no_half_lock;
		@(posedge mclk_i) disable iff (!arst_n_i)
		cfg_i.half_rate |=> !lock_o;
	endproperty
	a_no_half_lock: assert property (p_no_half_lock) else $error("lock in half rate"); // [RQ10]

	property p_man_step;
		@(posedge mclk_i) disable iff (!arst_n_i)
		man_up && !dly_i.delay_clear && !rx_rst_i
			|=> delay_tap_o == $past(delay_tap_o) + 5'h1;
	endproperty
	a_man_step: assert property (p_man_step) else $error("tap did not step"); // [RQ15]

	property p_clear;
		@(posedge mclk_i) disable iff (!arst_n_i)
		dly_i.delay_clear |=> (delay_tap_o == `HSL_TAP_RESET) && !lock_o;
	endproperty
	a_clear: assert property (p_clear) else $error("delay clear ignored"); // [RQ16]

	property p_alt;
		@(posedge mclk_i) disable iff (!arst_n_i)
		!$past(alt_ok) |-> !alternate_clock_out_o;
	endproperty
	a_alt: assert property (p_alt) else $error("alternate out outside bypass"); // [RQ17]

	property p_tx_rst;
		@(posedge mclk_i) disable iff (!arst_n_i)
		tx_rst_i |=> (tx_pad_o == 2'h0) && !tx_word_taken_o;
	endproperty
	a_tx_rst: assert property (p_tx_rst) else $error("tx reset ignored"); // [RQ20]

	property p_invalid;
		@(posedge mclk_i) disable iff (!arst_n_i)
		(align_act && !lock_o && cfg_i.queue_en && queue_empty_o && !rx_rst_i)
			|=> queue_empty_o;
	endproperty
	a_invalid: assert property (p_invalid) else $error("word queued before lock"); // [RQ24]
endmodule : hsl_lane
